// ===== src/tdm_output_data_mux.sv
// Time-division output data multiplexer with stuff latches, port code and diagnostics
// Functional notes
// - Each clock pick one bit from fifteen channel inputs or the overhead bit.
// - Channel select passes three register stages before steering the output mux.
// - Selected bit is reclocked into true and complementary serial outputs.
// - Overhead bit is offered only in bit 0 of words 1 to 28.
// - Bit 0 of words 1 to 23 carries one of three stuff patterns.
// - Bit 0 of words 24 to 28 carries a five-bit port code.
// - Stuff acknowledges are latched on each minor frame transition.
// - Latched stuff drives its enable high and its active-low select low.
// - No acknowledge keeps both enables low and both selects high.
// - Select code 101 picks positive, 011 negative, 111 no action.
// - Outside the late word window the select comes from the stuff latches.
// - Inside the late window the select is word count low bits 000 to 101.
// - Port code sends frame count bits most significant first.
// - Any of three error inputs high sets data mux error next clock.
// - Word 29 and frame bit 1 retrigger timeouts; expiry raises an error input.
// - Functional and diagnostic serial outputs disagreeing raises an error input.
// - Four comparators check gated clocks; mismatch sets gated clock error next clock.
// - Self test forces both error flags; display reset clears them.
// - Frame transition is word 29 together with end of scan.
// - Frame counter advances each transition, flags 31 and wraps to 0.
`timescale 1ns/1ps

module tdm_output_data_mux
    import tdm_pkg::*;
#(
    parameter int NUM_CH = TDM_NUM_CH,
    parameter logic [15:0] W29_TIMEOUT = TDM_W29_TIMEOUT_RST,
    parameter logic [15:0] MF_TIMEOUT = TDM_MF_TIMEOUT_RST
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic [NUM_CH:1] channelDataIn,
    input wire logic [TDM_SEL_W-1:0] muxChannelSelect,
    input wire logic [4:0] wordCountBit,
    input wire logic bitZero,
    input wire logic lateWordWindow,
    input wire logic word29Pulse,
    input wire logic endOfScanPulse,
    input wire logic posStuffAck,
    input wire logic negStuffAck,
    input wire logic posStuffPattern,
    input wire logic negStuffPattern,
    input wire logic noActionPattern,
    input wire logic diagSerialIn,
    input wire logic [NUM_CH:1] channelGatedClock,
    input wire logic [NUM_CH:1] diagGatedClock,
    output logic serialOut,
    output logic serialOutN,
    output logic posStuffEnable,
    output logic negStuffEnable,
    output logic posStuffSelN,
    output logic negStuffSelN,
    output logic [4:0] frameCountBit,
    output logic frameTerminal,
    output logic dataMuxError,
    output logic gatedClockError
);

    tdm_state_t cur;
    tdm_state_t next_cur;

    // ==========================================================
    // Overhead path
    function automatic logic [2:0] stuffCode(input logic pos, input logic neg);
        if (pos) begin
            stuffCode = TDM_CODE_POS;
        end else if (neg) begin
            stuffCode = TDM_CODE_NEG;
        end else begin
            stuffCode = TDM_CODE_NONE;
        end
    endfunction

    logic [2:0] ovhSel;
    logic ovhActive;
    logic ovhBit;
    logic muxBit;
    logic frameTransition;
    logic w29Expired;
    logic mfExpired;
    logic serialMismatch;
    logic dmErrCond;
    logic [TDM_CMP_GROUPS-1:0] grpEqual;
    logic gcMismatch;
    logic [TDM_CMP_GROUPS*TDM_CMP_WIDTH-1:0] funcGc;
    logic [TDM_CMP_GROUPS*TDM_CMP_WIDTH-1:0] diagGc;

    assign frameTransition = word29Pulse & endOfScanPulse;
    assign ovhActive = bitZero && (wordCountBit >= TDM_OVH_FIRST_WORD)
        && (wordCountBit <= TDM_OVH_LAST_WORD);

    always_comb begin
        // Late window steps the port code index, else the latched command
        if (lateWordWindow) begin
            ovhSel = wordCountBit[2:0];
        end else begin
            ovhSel = stuffCode(cur.posLatch, cur.negLatch);
        end
        ovhBit = 1'b0;
        if (ovhActive) begin
            if (lateWordWindow) begin
                if (ovhSel <= TDM_PORT_LAST_IDX) begin
                    ovhBit = cur.frameCount[3'h4 - ovhSel];
                end
            end else begin
                unique case (ovhSel)
                    TDM_CODE_POS: ovhBit = posStuffPattern;
                    TDM_CODE_NEG: ovhBit = negStuffPattern;
                    default: ovhBit = noActionPattern;
                endcase
            end
        end
    end

    // ==========================================================
    // Output data multiplexer
    always_comb begin
        // Select zero is the overhead slot; codes above the channel count read low
        muxBit = 1'b0;
        if (cur.addrDly[TDM_DELAY_STAGES-1] == '0) begin
            muxBit = ovhBit;
        end else if (int'(cur.addrDly[TDM_DELAY_STAGES-1]) <= NUM_CH) begin
            muxBit = channelDataIn[int'(cur.addrDly[TDM_DELAY_STAGES-1])];
        end
    end

    // ==========================================================
    // Diagnostics
    assign w29Expired = (cur.w29Timer == 16'h0000);
    assign mfExpired = (cur.mfTimer == 16'h0000);
    assign serialMismatch = cur.serialOut ^ diagSerialIn;
    assign dmErrCond = w29Expired | mfExpired | serialMismatch;
    assign funcGc = {{(TDM_CMP_GROUPS*TDM_CMP_WIDTH-NUM_CH){1'b0}}, channelGatedClock};
    assign diagGc = {{(TDM_CMP_GROUPS*TDM_CMP_WIDTH-NUM_CH){1'b0}}, diagGatedClock};

    // Each comparator takes eight inputs: four functional, four diagnostic
    genvar g;
    generate
        for (g = 0; g < TDM_CMP_GROUPS; g++) begin : gen_cmp
            assign grpEqual[g] = funcGc[g*TDM_CMP_WIDTH +: TDM_CMP_WIDTH]
                == diagGc[g*TDM_CMP_WIDTH +: TDM_CMP_WIDTH];
        end
    endgenerate
    assign gcMismatch = ~&grpEqual;

    // ==========================================================
    // Next state
    logic apbSetup;
    logic apbWrite;
    logic mapped;
    logic [31:0] rdValue;

    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & cur.pready & pwrite;
    assign mapped = (paddr == TDM_OFF_CTRL) || (paddr == TDM_OFF_STATUS)
        || (paddr == TDM_OFF_W29_TIMEOUT) || (paddr == TDM_OFF_MF_TIMEOUT);

    always_comb begin
        rdValue = 32'h0000_0000;
        unique case (paddr)
            TDM_OFF_CTRL: rdValue[TDM_CTRL_SELF_TEST] = cur.selfTest;
            TDM_OFF_STATUS: begin
                rdValue[TDM_ST_DM_ERR] = cur.dataMuxErr;
                rdValue[TDM_ST_GC_ERR] = cur.gatedClockErr;
                rdValue[TDM_ST_POS_EN] = cur.posLatch;
                rdValue[TDM_ST_NEG_EN] = cur.negLatch;
                rdValue[TDM_ST_W29_EXP] = w29Expired;
                rdValue[TDM_ST_MF_EXP] = mfExpired;
                rdValue[TDM_ST_FRAME_LSB +: 5] = cur.frameCount;
                rdValue[TDM_ST_FRAME_TERM] = cur.frameTerminal;
            end
            TDM_OFF_W29_TIMEOUT: rdValue[15:0] = cur.w29Limit;
            TDM_OFF_MF_TIMEOUT: rdValue[15:0] = cur.mfLimit;
            default: rdValue = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_cur = cur;
        // Shift register on the select compensates the channel data latency
        next_cur.addrDly[0] = muxChannelSelect;
        for (int i = 1; i < TDM_DELAY_STAGES; i++) begin
            next_cur.addrDly[i] = cur.addrDly[i-1];
        end
        next_cur.serialOut = muxBit;
        next_cur.serialOutN = ~muxBit;
        if (frameTransition) begin
            next_cur.posLatch = posStuffAck;
            next_cur.negLatch = negStuffAck;
            next_cur.posSelN = ~posStuffAck;
            next_cur.negSelN = ~negStuffAck;
            next_cur.frameCount = cur.frameCount + 5'h01;
            next_cur.frameTerminal = (cur.frameCount + 5'h01) == TDM_FRAME_MAX;
        end
        // Timers count down to zero and park there until retriggered
        next_cur.mfcBit1Prev = cur.frameCount[1];
        if (word29Pulse) begin
            next_cur.w29Timer = cur.w29Limit;
        end else if (!w29Expired) begin
            next_cur.w29Timer = cur.w29Timer - 16'h0001;
        end
        if (cur.frameCount[1] != cur.mfcBit1Prev) begin
            next_cur.mfTimer = cur.mfLimit;
        end else if (!mfExpired) begin
            next_cur.mfTimer = cur.mfTimer - 16'h0001;
        end
        // A live fault or self test wins over display reset
        if (cur.selfTest || dmErrCond) begin
            next_cur.dataMuxErr = 1'b1;
        end else if (cur.dispReset) begin
            next_cur.dataMuxErr = 1'b0;
        end
        if (cur.selfTest || gcMismatch) begin
            next_cur.gatedClockErr = 1'b1;
        end else if (cur.dispReset) begin
            next_cur.gatedClockErr = 1'b0;
        end
        // Register bus: one wait-free access cycle after setup
        next_cur.pready = apbSetup;
        next_cur.dispReset = 1'b0;
        if (apbSetup) begin
            next_cur.prdata = pwrite ? 32'h0000_0000 : rdValue;
            next_cur.pslverr = ~mapped;
        end
        if (apbWrite) begin
            unique case (paddr)
                TDM_OFF_CTRL: begin
                    next_cur.selfTest = pwdata[TDM_CTRL_SELF_TEST];
                    next_cur.dispReset = pwdata[TDM_CTRL_DISP_RESET];
                end
                TDM_OFF_W29_TIMEOUT: next_cur.w29Limit = pwdata[15:0];
                TDM_OFF_MF_TIMEOUT: next_cur.mfLimit = pwdata[15:0];
                default: next_cur.pslverr = cur.pslverr;
            endcase
        end
    end

    // ==========================================================
    // State register
    // Reset image: serial pair and selects idle, timers armed full
    function automatic tdm_state_t resetState();
        tdm_state_t r;
        r = '0;
        r.serialOutN = 1'b1;
        r.posSelN = 1'b1;
        r.negSelN = 1'b1;
        r.w29Timer = W29_TIMEOUT;
        r.mfTimer = MF_TIMEOUT;
        r.w29Limit = W29_TIMEOUT;
        r.mfLimit = MF_TIMEOUT;
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= resetState();
        end else begin
            cur <= next_cur;
        end
    end

    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign prdata = cur.prdata;
    assign serialOut = cur.serialOut;
    assign serialOutN = cur.serialOutN;
    assign posStuffEnable = cur.posLatch;
    assign negStuffEnable = cur.negLatch;
    assign posStuffSelN = cur.posSelN;
    assign negStuffSelN = cur.negSelN;
    assign frameCountBit = cur.frameCount;
    assign frameTerminal = cur.frameTerminal;
    assign dataMuxError = cur.dataMuxErr;
    assign gatedClockError = cur.gatedClockErr;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence sqFrameEdge;
        frameTransition;
    endsequence

    sequence sqLatchedPos;
        ##1 posStuffEnable && !posStuffSelN;
    endsequence

    sequence sqLatchedNeg;
        ##1 negStuffEnable && !negStuffSelN;
    endsequence

    chk_select_delay: assert property (
        $past(rst_n, 3) |-> cur.addrDly[TDM_DELAY_STAGES-1] == $past(muxChannelSelect, 3))
        else $error("channel select not delayed by three clocks");

    chk_serial_pair: assert property (
        serialOut != serialOutN)
        else $error("serial outputs are not complementary");

    chk_mux_follow: assert property (
        1'b1 |=> serialOut == $past(muxBit))
        else $error("serial output does not follow selected bit");

    chk_ovh_window: assert property (
        !ovhActive |-> !ovhBit)
        else $error("overhead bit offered outside its window");

    chk_stuff_latch: assert property (
        sqFrameEdge |=> posStuffEnable == $past(posStuffAck)
            && negStuffEnable == $past(negStuffAck))
        else $error("stuff acknowledge not latched at frame transition");

    chk_pos_select: assert property (
        sqFrameEdge and posStuffAck |-> sqLatchedPos)
        else $error("positive stuff enable or select wrong");

    chk_sel_pairing: assert property (
        posStuffSelN == !posStuffEnable && negStuffSelN == !negStuffEnable)
        else $error("stuff select does not mirror enable");

    chk_pos_code: assert property (
        ovhActive && !lateWordWindow && cur.posLatch |-> ovhBit == posStuffPattern)
        else $error("positive stuff pattern not chosen");

    chk_port_msb: assert property (
        ovhActive && lateWordWindow && wordCountBit[2:0] == 3'h0
            |-> ovhBit == frameCountBit[4])
        else $error("port code does not start with frame count msb");

    chk_frame_step: assert property (
        sqFrameEdge |=> frameCountBit == 5'($past(frameCountBit) + 5'h01))
        else $error("frame counter did not advance");

    chk_dm_error: assert property (
        dmErrCond |=> dataMuxError)
        else $error("data mux error not set after fault");

    chk_gc_error: assert property (
        gcMismatch |=> gatedClockError)
        else $error("gated clock error not set after mismatch");

    chk_self_test: assert property (
        cur.selfTest |=> dataMuxError && gatedClockError)
        else $error("self test did not force error flags");

    chk_w29_reload: assert property (
        word29Pulse |=> !w29Expired || $past(cur.w29Limit) == 16'h0000)
        else $error("word 29 timeout not retriggered");

    chk_neg_select: assert property (
        sqFrameEdge and negStuffAck |-> sqLatchedNeg)
        else $error("negative stuff enable or select wrong");

    chk_no_action: assert property (
        frameTransition && !posStuffAck && !negStuffAck |=> !posStuffEnable
            && !negStuffEnable && posStuffSelN && negStuffSelN)
        else $error("no action frame left a stuff enable set");

    chk_neg_code: assert property (
        ovhActive && !lateWordWindow && !cur.posLatch && cur.negLatch
            |-> ovhBit == negStuffPattern)
        else $error("negative stuff pattern not chosen");

    chk_gc_clear: assert property (
        cur.dispReset && !cur.selfTest && !gcMismatch |=> !gatedClockError)
        else $error("display reset did not clear gated clock error");

endmodule

// ===== src/tdm_pkg.sv
// Package: constants and types of the time-division output data multiplexer
package tdm_pkg;

    // ==========================================================
    // Structure
    localparam int TDM_NUM_CH = 15;
    localparam int TDM_SEL_W = 4;
    localparam int TDM_DELAY_STAGES = 3;
    localparam int TDM_CMP_GROUPS = 4;
    localparam int TDM_CMP_WIDTH = 4;

    // ==========================================================
    // Frame and overhead timing
    localparam logic [4:0] TDM_OVH_FIRST_WORD = 5'h01;
    localparam logic [4:0] TDM_OVH_LAST_WORD = 5'h1C;
    localparam logic [4:0] TDM_FRAME_MAX = 5'h1F;
    localparam logic [2:0] TDM_CODE_POS = 3'h5;
    localparam logic [2:0] TDM_CODE_NEG = 3'h3;
    localparam logic [2:0] TDM_CODE_NONE = 3'h7;
    localparam logic [2:0] TDM_PORT_LAST_IDX = 3'h4;
    localparam logic [15:0] TDM_W29_TIMEOUT_RST = 16'h2000;
    localparam logic [15:0] TDM_MF_TIMEOUT_RST = 16'h8000;

    // ==========================================================
    // Register map
    localparam logic [7:0] TDM_OFF_CTRL = 8'h00;
    localparam logic [7:0] TDM_OFF_STATUS = 8'h04;
    localparam logic [7:0] TDM_OFF_W29_TIMEOUT = 8'h08;
    localparam logic [7:0] TDM_OFF_MF_TIMEOUT = 8'h0C;
    localparam int TDM_CTRL_SELF_TEST = 0;
    localparam int TDM_CTRL_DISP_RESET = 1;
    localparam int TDM_ST_DM_ERR = 0;
    localparam int TDM_ST_GC_ERR = 1;
    localparam int TDM_ST_POS_EN = 2;
    localparam int TDM_ST_NEG_EN = 3;
    localparam int TDM_ST_W29_EXP = 4;
    localparam int TDM_ST_MF_EXP = 5;
    localparam int TDM_ST_FRAME_LSB = 8;
    localparam int TDM_ST_FRAME_TERM = 13;

    // ==========================================================
    // Block state
    typedef struct packed {
        logic [TDM_DELAY_STAGES-1:0][TDM_SEL_W-1:0] addrDly;
        logic serialOut;
        logic serialOutN;
        logic posLatch;
        logic negLatch;
        logic posSelN;
        logic negSelN;
        logic [4:0] frameCount;
        logic frameTerminal;
        logic [15:0] w29Timer;
        logic [15:0] mfTimer;
        logic mfcBit1Prev;
        logic dataMuxErr;
        logic gatedClockErr;
        logic selfTest;
        logic dispReset;
        logic [15:0] w29Limit;
        logic [15:0] mfLimit;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tdm_state_t;

endpackage

// ===== tb/tb.sv
// Testbench: random traffic, frame model and error scenarios for the output data mux
`timescale 1ns/1ps

module tb;
    import tdm_pkg::*;
    localparam logic [15:0] W29_LIM = 16'h0100;
    localparam logic [15:0] MF_LIM = 16'h0200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [15:1] chData = '0, chGc = '0, gcFlip = '0;
    logic [3:0] sel = 4'h0;
    logic posAck = 1'b0, negAck = 1'b0, posPat = 1'b0, negPat = 1'b0, noPat = 1'b0;
    logic dFlip = 1'b0, run = 1'b0, randOn = 1'b0, started = 1'b0;
    logic [4:0] word, frameCountBit, expFrame;
    logic bitZero, late, w29, eos, serialOut, serialOutN, posEn, negEn, posSelN, negSelN;
    logic frameTerminal, dmErr, gcErr, expSer, expPos, expNeg;
    logic [3:0] sh [3];
    int nMismatch = 0;
    int cmpCount = 0;

    tdm_output_data_mux #(.NUM_CH(15), .W29_TIMEOUT(W29_LIM), .MF_TIMEOUT(MF_LIM)) u_dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .channelDataIn(chData), .muxChannelSelect(sel), .wordCountBit(word),
        .bitZero(bitZero), .lateWordWindow(late), .word29Pulse(w29), .endOfScanPulse(eos),
        .posStuffAck(posAck), .negStuffAck(negAck), .posStuffPattern(posPat),
        .negStuffPattern(negPat), .noActionPattern(noPat), .diagSerialIn(serialOut ^ dFlip),
        .channelGatedClock(chGc), .diagGatedClock(chGc ^ gcFlip), .serialOut(serialOut),
        .serialOutN(serialOutN), .posStuffEnable(posEn), .negStuffEnable(negEn),
        .posStuffSelN(posSelN), .negStuffSelN(negSelN), .frameCountBit(frameCountBit),
        .frameTerminal(frameTerminal), .dataMuxError(dmErr), .gatedClockError(gcErr)
    );

    tdm_frame_timer #(.BITS(4)) u_timer (
        .clk(clk), .rst_n(rst_n), .run(run), .wordCountBit(word), .bitZero(bitZero),
        .lateWordWindow(late), .word29Pulse(w29), .endOfScanPulse(eos)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // Checking and bus tasks
    task check(input logic [32:0] seen, input logic [32:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task end_of_test();
        $display("mismatches=%0d comparisons=%0d", nMismatch, cmpCount);
        if (nMismatch == 0 && cmpCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Overhead bit expected at this edge, from the model's latched state
    function logic ovh();
        if (!bitZero || word > 5'h1C) return 1'b0;
        if (!late) return expPos ? posPat : (expNeg ? negPat : noPat);
        return (word[2:0] <= 3'h4) ? expFrame[3'h4 - word[2:0]] : 1'b0;
    endfunction

    // ==========================================================
    // Cycle model of serial path, stuff latches and frame counter
    always @(posedge clk) begin
        if (started) begin
            check(serialOut, expSer);
            check(serialOutN, !expSer);
            check({posEn, negEn, posSelN, negSelN}, {expPos, expNeg, ~expPos, ~expNeg});
            check({frameTerminal, frameCountBit}, {expFrame == 5'h1F, expFrame});
        end
        if (!rst_n) begin
            sh[0] = 4'h0;
            sh[1] = 4'h0;
            sh[2] = 4'h0;
            {expSer, expPos, expNeg, expFrame} = '0;
            started = 1'b1;
        end else begin
            expSer = (sh[2] == 4'h0) ? ovh() : chData[sh[2]];
            if (w29 && eos) begin
                expPos = posAck;
                expNeg = negAck;
                expFrame = expFrame + 5'h01;
            end
            sh[2] = sh[1];
            sh[1] = sh[0];
            sh[0] = sel;
        end
    end

    always @(posedge clk) begin
        if (randOn) begin
            chData <= 15'($urandom);
            sel <= ($urandom_range(2) == 0) ? 4'h0 : 4'($urandom);
            {posAck, negAck, posPat, negPat, noPat} <= 5'($urandom);
            chGc <= 15'($urandom);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h1EF58493));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        randOn <= 1'b1;
        apb(1'b0, TDM_OFF_CTRL, 32'h0);
        check({err, rd}, 33'h0);
        apb(1'b0, TDM_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, TDM_OFF_W29_TIMEOUT, 32'h0);
        check(rd, {16'h0, W29_LIM});
        apb(1'b0, TDM_OFF_MF_TIMEOUT, 32'h0);
        check(rd, {16'h0, MF_LIM});
        apb(1'b1, TDM_OFF_W29_TIMEOUT, 32'h0180);
        apb(1'b0, TDM_OFF_W29_TIMEOUT, 32'h0);
        check(rd, 32'h0180);
        apb(1'b1, TDM_OFF_W29_TIMEOUT, {16'h0, W29_LIM});
        apb(1'b0, 8'h10, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        // Long enough to pass frame 31 and wrap
        repeat (34 * 116) @(posedge clk);
        check({gcErr, dmErr}, 2'b00);
        @(posedge clk) dFlip <= 1'b1;
        @(posedge clk) dFlip <= 1'b0;
        #1 check(dmErr, 1'b1);
        apb(1'b1, TDM_OFF_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        #1 check(dmErr, 1'b0);
        for (int g = 0; g < 4; g++) begin
            @(posedge clk) gcFlip <= 15'h1 << (4 * g);
            @(posedge clk) gcFlip <= '0;
            #1 check(gcErr, 1'b1);
            apb(1'b1, TDM_OFF_CTRL, 32'h2);
            repeat (2) @(posedge clk);
            #1 check(gcErr, 1'b0);
        end
        apb(1'b1, TDM_OFF_CTRL, 32'h3);
        apb(1'b0, TDM_OFF_CTRL, 32'h0);
        check(rd, 32'h1);
        check({gcErr, dmErr}, 2'b11);
        apb(1'b1, TDM_OFF_CTRL, 32'h0);
        apb(1'b1, TDM_OFF_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        #1 check({gcErr, dmErr}, 2'b00);
        // Starve both timers; word 29 limit is the shorter one
        @(posedge clk) run <= 1'b0;
        repeat (265) @(posedge clk);
        apb(1'b0, TDM_OFF_STATUS, 32'h0);
        check(rd[5:4], 2'b01);
        repeat (330) @(posedge clk);
        apb(1'b0, TDM_OFF_STATUS, 32'h0);
        check({rd[5:4], rd[0]}, 3'b111);
        @(posedge clk) run <= 1'b1;
        repeat (300) @(posedge clk);
        apb(1'b1, TDM_OFF_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        #1 check(dmErr, 1'b0);
        end_of_test();
    end
endmodule

// ===== tb/tdm_frame_timer.sv
// Frame timing partner: word counter, bit zero, late window, word 29 and end of scan
`timescale 1ns/1ps

module tdm_frame_timer #(
    parameter int BITS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic [4:0] wordCountBit,
    output logic bitZero,
    output logic lateWordWindow,
    output logic word29Pulse,
    output logic endOfScanPulse
);
    logic [7:0] bitCnt;

    // ==========================================================
    // Word and bit counters, frozen while stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitCnt <= 8'h00;
            wordCountBit <= 5'h01;
        end else if (run) begin
            if (bitCnt == 8'(BITS - 1)) begin
                bitCnt <= 8'h00;
                wordCountBit <= (wordCountBit == 5'h1D) ? 5'h01 : wordCountBit + 5'h01;
            end else begin
                bitCnt <= bitCnt + 8'h01;
            end
        end
    end

    // Pulses vanish when stopped so the activity timers really starve
    assign bitZero = run && (bitCnt == 8'h00);
    assign endOfScanPulse = run && (bitCnt == 8'(BITS - 1));
    assign word29Pulse = run && (wordCountBit == 5'h1D);
    assign lateWordWindow = (wordCountBit >= 5'h18);
endmodule
